/* File: src/ccm_params.svh */
// Constants for the compact CPU core: memory map, reset values, fields.
// Assumes inclusion by bare name from every file that needs them.
`ifndef CCM_PARAMS_SVH
`define CCM_PARAMS_SVH
// Program memory map and memory sizes
`define CCM_FLASH_BYTES 8320
`define CCM_RSV_LO 16'h1E00
`define CCM_RSV_HI 16'h1FFF
`define CCM_ERASED 8'hFF
`define CCM_ON_CHIP_EXTENDED_RAM_BYTES 1024
`define CCM_DRAM_BYTES 256
// Reset values
`define CCM_RESET_PC 16'h0000
`define CCM_SP_RST 8'h07
`define CCM_P0_RST 8'hFF
// Special register addresses
`define CCM_SFR_P0 8'h80
`define CCM_SFR_SP 8'h81
`define CCM_SFR_DPL 8'h82
`define CCM_SFR_DPH 8'h83
`define CCM_SFR_PROGRAM_STORE_CONTROL 8'h8F
`define CCM_SFR_PSW 8'hD0
`define CCM_SFR_ACC 8'hE0
// Direct address bit that selects special registers
`define CCM_DIR_SFR 7
// First byte of the bit-addressable area
`define CCM_BIT_BASE 8'h20
// Status word fields
`define CCM_PSW_CY 7
`define CCM_PSW_AC 6
`define CCM_PSW_BANK_HI 4
`define CCM_PSW_BANK_LO 3
`define CCM_PSW_OV 2
// Program store control write enable bit
`define CCM_PROGRAM_STORE_CONTROL_WE 0
// Instruction lengths and extra data cycles
`define CCM_LEN1 2'd1
`define CCM_LEN2 2'd2
`define CCM_LEN3 2'd3
`define CCM_EXT_NONE 2'd0
`define CCM_EXT_ONE 2'd1
`define CCM_EXT_TWO 2'd2
`endif

/* File: src/ccm_pkg.sv */
// Types shared by the compact CPU core and its memories.
// Assumes nothing beyond a SystemVerilog compiler.
package ccm_pkg;
  typedef logic [7:0] ccm_byte_t;
  typedef logic [15:0] ccm_addr_t;
  typedef enum logic [1:0] {ST_FETCH, ST_EXTRA, ST_BUBBLE} ccm_state_e;
endpackage

/* File: src/ccm_mem_if.sv */
// Carrier between core and its code/external and data memories.
// Assumes all ends run on the core clock.
`timescale 1ns/1ps
`default_nettype none
interface ccm_mem_if;
  import ccm_pkg::*;
  ccm_addr_t code_addr;
  ccm_byte_t code_rdata;
  ccm_addr_t x_addr;
  ccm_byte_t x_wdata;
  ccm_byte_t x_rdata;
  logic x_we;
  logic flash_sel;
  ccm_byte_t ra_addr;
  ccm_byte_t ra_rdata;
  ccm_byte_t rb_addr;
  ccm_byte_t rb_rdata;
  ccm_byte_t w_addr;
  ccm_byte_t w_data;
  logic w_en;
  modport core(output code_addr, x_addr, x_wdata, x_we, flash_sel,
    output ra_addr, rb_addr, w_addr, w_data, w_en,
    input code_rdata, x_rdata, ra_rdata, rb_rdata);
  modport code(input code_addr, x_addr, x_wdata, x_we, flash_sel,
    output code_rdata, x_rdata);
  modport data(input ra_addr, rb_addr, w_addr, w_data, w_en,
    output ra_rdata, rb_rdata);
endinterface
`default_nettype wire

/* File: src/ccm_dmem.sv */
// Internal data RAM: two read ports, one write port.
// Assumes addresses already resolved by the core.
`timescale 1ns/1ps
`default_nettype none
`include "ccm_params.svh"
module ccm_dmem #(
  parameter int DEPTH = `CCM_DRAM_BYTES
) (
  input wire logic clk,
  input wire logic en,
  ccm_mem_if.data m
);
  import ccm_pkg::*;
  ccm_byte_t ram [DEPTH];

  // Write when the core is enabled
  always_ff @(posedge clk) begin
    if (en && m.w_en) begin
      ram[m.w_addr] <= m.w_data;
    end
  end

  // Asynchronous reads
  assign m.ra_rdata = ram[m.ra_addr];
  assign m.rb_rdata = ram[m.rb_addr];
endmodule
`default_nettype wire

/* File: src/ccm_xmem.sv */
// Flash program store and on-chip extended RAM.
// Assumes the loader is idle while the core writes program memory.
`timescale 1ns/1ps
`default_nettype none
`include "ccm_params.svh"
module ccm_xmem #(
  parameter int FLASH_BYTES = `CCM_FLASH_BYTES,
  parameter int ON_CHIP_EXTENDED_RAM_BYTES = `CCM_ON_CHIP_EXTENDED_RAM_BYTES
) (
  input wire logic clk,
  input wire logic en,
  input wire logic ld_en,
  input wire ccm_pkg::ccm_addr_t ld_addr,
  input wire ccm_pkg::ccm_byte_t ld_data,
  ccm_mem_if.code m
);
  import ccm_pkg::*;
  localparam int FA_W = $clog2(FLASH_BYTES);
  localparam int XA_W = $clog2(ON_CHIP_EXTENDED_RAM_BYTES);
  ccm_byte_t flash [FLASH_BYTES];
  ccm_byte_t on_chip_extended_ram [ON_CHIP_EXTENDED_RAM_BYTES];
  logic code_ok;
  logic wr_ok;
  logic rsv;

  // Range checks; the reserved pages never take core writes
  assign code_ok = m.code_addr < 16'(FLASH_BYTES);
  assign rsv = (m.x_addr >= `CCM_RSV_LO) && (m.x_addr <= `CCM_RSV_HI);
  assign wr_ok = (m.x_addr < 16'(FLASH_BYTES)) && !rsv;

  // Loader first, then core writes only with write enable set
  always_ff @(posedge clk) begin
    if (ld_en && (ld_addr < 16'(FLASH_BYTES))) begin
      flash[ld_addr[FA_W-1:0]] <= ld_data;
    end else if (en && m.x_we && m.flash_sel && wr_ok) begin
      flash[m.x_addr[FA_W-1:0]] <= m.x_wdata;
    end
  end

  // Extended RAM writes when program store is not selected
  always_ff @(posedge clk) begin
    if (en && m.x_we && !m.flash_sel) begin
      on_chip_extended_ram[m.x_addr[XA_W-1:0]] <= m.x_wdata;
    end
  end

  // Reads; outside the flash reads as erased
  assign m.code_rdata = code_ok ? flash[m.code_addr[FA_W-1:0]]
                                : `CCM_ERASED;
  assign m.x_rdata = on_chip_extended_ram[m.x_addr[XA_W-1:0]];
endmodule
`default_nettype wire

/* File: src/ccm_core.sv */
// Compact 8-bit CPU core with its memory map and cycle timing.
// Assumes a program loaded over the ld_* port while in reset.
//
// What this block does
// - Most instructions take one clock per program byte.
// - Untaken conditional branch takes one clock less than taken.
// - Most instructions take one or two clocks, none above eight.
// - Timing counted in plain clocks, no machine cycles.
// - Standard opcodes, addressing modes and status flag effects.
// - The one spare opcode behaves as a no-operation.
// - No external bus; external moves reach flash and extended RAM.
// - Program flash is one 8320 byte block from address zero.
// - Factory pages 0x1E00 to 0x1FFF hold no user code.
// - External writes reach flash only with store write enable set.
// - Software reads and changes flash one byte per access.
// - 256 bytes data RAM, lower half direct and indirect.
// - Bytes 0x00 to 0x1F are four banks of eight registers.
// - Bytes 0x20 to 0x2F are also 128 addressable bits.
// - Above 0x7F direct selects special registers, indirect upper RAM.
// - Direct 0x00 to 0x7F is RAM, 0x80 to 0xFF special registers.
// - Relative jumps add signed offset to next instruction address.
// - Absolute jumps stay inside the 2 kB page of next instruction.
// - Long jumps and calls take a full 16-bit target.
// - Indirect uses R0 or R1; register operands use active bank.
// - Status word bits 3 and 4 select the register bank.
`timescale 1ns/1ps
`default_nettype none
`include "ccm_params.svh"
module ccm_core (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic ld_en,
  input wire ccm_pkg::ccm_addr_t ld_addr,
  input wire ccm_pkg::ccm_byte_t ld_data,
  output var ccm_pkg::ccm_addr_t pc,
  output var ccm_pkg::ccm_byte_t acc,
  output var ccm_pkg::ccm_byte_t program_status_word,
  output var ccm_pkg::ccm_byte_t p0,
  output var logic instr_done
);
  import ccm_pkg::*;

  ccm_state_e st_q;
  ccm_addr_t pc_q, dptr_q, tgt_q;
  ccm_byte_t op_q, b1_q, acc_q, psw_q, sp_q, p0_q, hold_q;
  logic [1:0] cnt_q, ext_q;
  logic program_store_control_we_q, done_q;

  ccm_byte_t cur, opc, op1, op2, rn_addr, ri_addr, ba_addr, bit_byte;
  ccm_byte_t acc_n, psw_n, sp_n, p0_n, hold_n, dir_rd, addx;
  ccm_byte_t dst_dir, dst_val, ind_addr, ind_val;
  ccm_addr_t nxt, rel_tgt, abs_tgt, tgt_n, dptr_n, pc_n;
  logic [1:0] len, ext_n, bank;
  logic last, take, dst_we, ind_we, program_store_control_n, done_n, do_add, save_tgt;
  logic [8:0] sum9;
  logic [4:0] sum5;

  ccm_mem_if mif();

  ccm_dmem u_dmem (
    .clk(ref_clk),
    .en(clk_en),
    .m(mif)
  );

  ccm_xmem u_xmem (
    .clk(ref_clk),
    .en(clk_en),
    .ld_en(ld_en),
    .ld_addr(ld_addr),
    .ld_data(ld_data),
    .m(mif)
  );

  // Byte count by opcode; anything unlisted is one byte
  function automatic logic [1:0] op_len(input ccm_byte_t op);
    casez (op)
      8'h02, 8'h12, 8'h75, 8'h90, 8'h20, 8'h30: op_len = `CCM_LEN3;
      8'h74, 8'h24, 8'hE5, 8'hF5, 8'h80, 8'h60, 8'h70, 8'h40,
      8'h50, 8'hD2, 8'hC2, 8'b1101_1???, 8'b???0_0001,
      8'b???1_0001: op_len = `CCM_LEN2;
      default: op_len = `CCM_LEN1;
    endcase
  endfunction

  // Data cycles after the last program byte
  function automatic logic [1:0] op_ext(input ccm_byte_t op);
    casez (op)
      8'h12, 8'b???1_0001: op_ext = `CCM_EXT_ONE;
      8'h22, 8'h93, 8'hE0, 8'hF0: op_ext = `CCM_EXT_TWO;
      default: op_ext = `CCM_EXT_NONE;
    endcase
  endfunction

  // Special register read; unmapped addresses read zero
  function automatic ccm_byte_t sfr_rd(input ccm_byte_t a);
    case (a)
      `CCM_SFR_P0: sfr_rd = p0_q;
      `CCM_SFR_SP: sfr_rd = sp_q;
      `CCM_SFR_DPL: sfr_rd = dptr_q[7:0];
      `CCM_SFR_DPH: sfr_rd = dptr_q[15:8];
      `CCM_SFR_PROGRAM_STORE_CONTROL: sfr_rd = {7'h00, program_store_control_we_q};
      `CCM_SFR_PSW: sfr_rd = psw_q;
      `CCM_SFR_ACC: sfr_rd = acc_q;
      default: sfr_rd = 8'h00;
    endcase
  endfunction

  // Operand fields and address arithmetic
  assign cur = mif.code_rdata;
  assign opc = (cnt_q == 2'd0) ? cur : op_q;
  assign len = op_len(opc);
  assign last = (st_q == ST_FETCH) && (cnt_q == len - 2'd1);
  assign op1 = (len == `CCM_LEN3) ? b1_q : cur;
  assign op2 = cur;
  assign nxt = pc_q + 16'h0001;
  assign rel_tgt = nxt + {{8{op2[7]}}, op2};
  assign abs_tgt = {nxt[15:11], opc[7:5], op1};
  assign bank = psw_q[`CCM_PSW_BANK_HI:`CCM_PSW_BANK_LO];
  assign rn_addr = {3'b000, bank, opc[2:0]};
  assign ri_addr = {3'b000, bank, 2'b00, opc[0]};
  // Bit area bytes or bit-addressable special registers
  assign ba_addr = op1[`CCM_DIR_SFR] ? {op1[7:3], 3'b000}
                 : (`CCM_BIT_BASE + {4'h0, op1[6:3]});

  // Memory port addresses; code port turns to the table during lookups
  assign mif.rb_addr = ri_addr;
  assign mif.code_addr = (st_q == ST_EXTRA && op_q == 8'h93)
                       ? dptr_q + {8'h00, acc_q} : pc_q;
  assign mif.x_addr = dptr_q;
  assign mif.x_wdata = acc_q;
  assign mif.x_we = (st_q == ST_EXTRA) && (op_q == 8'hF0)
                  && (ext_q == `CCM_EXT_ONE);
  assign mif.flash_sel = program_store_control_we_q;

  // Data RAM read address by addressing mode
  always_comb begin
    mif.ra_addr = op1;
    casez (opc)
      8'b1110_1???, 8'b0010_1???, 8'b1101_1???: mif.ra_addr = rn_addr;
      8'hE6, 8'hE7: mif.ra_addr = mif.rb_rdata;
      8'hD2, 8'hC2, 8'h20, 8'h30: mif.ra_addr = ba_addr;
      default: ;
    endcase
    if (st_q == ST_EXTRA) begin
      mif.ra_addr = sp_q;
    end
  end

  // Direct operands split between RAM and special registers
  assign dir_rd = op1[`CCM_DIR_SFR] ? sfr_rd(op1)
                : mif.ra_rdata;
  assign bit_byte = ba_addr[`CCM_DIR_SFR] ? sfr_rd(ba_addr) : mif.ra_rdata;

  // Execute: next architectural state from the current instruction
  always_comb begin
    acc_n = acc_q;
    psw_n = psw_q;
    sp_n = sp_q;
    p0_n = p0_q;
    dptr_n = dptr_q;
    program_store_control_n = program_store_control_we_q;
    hold_n = hold_q;
    pc_n = pc_q;
    tgt_n = pc_q;
    take = 1'b0;
    save_tgt = 1'b0;
    dst_we = 1'b0;
    dst_dir = op1;
    dst_val = 8'h00;
    ind_we = 1'b0;
    ind_addr = sp_q + 8'h01;
    ind_val = 8'h00;
    do_add = 1'b0;
    addx = 8'h00;
    ext_n = `CCM_EXT_NONE;
    case (st_q)
      ST_FETCH: begin
        pc_n = nxt;
        if (last) begin
          ext_n = op_ext(opc);
          casez (opc)
            8'h00, 8'hA5: ;
            8'hE4: acc_n = 8'h00;
            8'hF4: acc_n = ~acc_q;
            8'h04: acc_n = acc_q + 8'h01;
            8'h14: acc_n = acc_q - 8'h01;
            8'hC3: psw_n[`CCM_PSW_CY] = 1'b0;
            8'hD3: psw_n[`CCM_PSW_CY] = 1'b1;
            8'h74: acc_n = op1;
            8'hE5: acc_n = dir_rd;
            8'b1110_1???, 8'hE6, 8'hE7: acc_n = mif.ra_rdata;
            8'hF5: begin
              dst_we = 1'b1;
              dst_val = acc_q;
            end
            8'h75: begin
              dst_we = 1'b1;
              dst_val = op2;
            end
            8'b1111_1???: begin
              ind_we = 1'b1;
              ind_addr = rn_addr;
              ind_val = acc_q;
            end
            8'hF6, 8'hF7: begin
              ind_we = 1'b1;
              ind_addr = mif.rb_rdata;
              ind_val = acc_q;
            end
            8'h24: begin
              do_add = 1'b1;
              addx = op1;
            end
            8'b0010_1???: begin
              do_add = 1'b1;
              addx = mif.ra_rdata;
            end
            8'hD2, 8'hC2: begin
              dst_we = 1'b1;
              dst_dir = ba_addr;
              dst_val = bit_byte;
              dst_val[op1[2:0]] = (opc == 8'hD2);
            end
            8'h20, 8'h30: begin
              take = (bit_byte[op1[2:0]] == (opc == 8'h20));
              tgt_n = rel_tgt;
            end
            8'h80: begin
              take = 1'b1;
              tgt_n = rel_tgt;
            end
            8'h60, 8'h70: begin
              take = ((acc_q == 8'h00) == (opc == 8'h60));
              tgt_n = rel_tgt;
            end
            8'h40, 8'h50: begin
              take = (psw_q[`CCM_PSW_CY] == (opc == 8'h40));
              tgt_n = rel_tgt;
            end
            8'b1101_1???: begin
              ind_we = 1'b1;
              ind_addr = rn_addr;
              ind_val = mif.ra_rdata - 8'h01;
              take = (ind_val != 8'h00);
              tgt_n = rel_tgt;
            end
            8'b???0_0001: begin
              take = 1'b1;
              tgt_n = abs_tgt;
            end
            8'h02: begin
              take = 1'b1;
              tgt_n = {b1_q, cur};
            end
            8'b???1_0001, 8'h12: begin
              // Push return low byte now, high byte next cycle
              ind_we = 1'b1;
              ind_val = nxt[7:0];
              sp_n = sp_q + 8'h01;
              hold_n = nxt[15:8];
              save_tgt = 1'b1;
              tgt_n = (opc == 8'h12) ? {b1_q, cur} : abs_tgt;
            end
            8'h90: dptr_n = {b1_q, cur};
            8'hA3: dptr_n = dptr_q + 16'h0001;
            default: ;
          endcase
          if (take) begin
            pc_n = tgt_n;
          end
        end
      end
      ST_EXTRA: begin
        casez (op_q)
          8'b???1_0001, 8'h12: begin
            ind_we = 1'b1;
            ind_val = hold_q;
            sp_n = sp_q + 8'h01;
            pc_n = tgt_q;
          end
          8'h22: begin
            sp_n = sp_q - 8'h01;
            if (ext_q == `CCM_EXT_TWO) begin
              hold_n = mif.ra_rdata;
            end else begin
              pc_n = {hold_q, mif.ra_rdata};
            end
          end
          8'h93: if (ext_q == `CCM_EXT_ONE) acc_n = mif.code_rdata;
          8'hE0: if (ext_q == `CCM_EXT_ONE) acc_n = mif.x_rdata;
          default: ;
        endcase
      end
      default: ;
    endcase
    // Addition flags
    sum9 = {1'b0, acc_q} + {1'b0, addx};
    sum5 = {1'b0, acc_q[3:0]} + {1'b0, addx[3:0]};
    if (do_add) begin
      acc_n = sum9[7:0];
      psw_n[`CCM_PSW_CY] = sum9[8];
      psw_n[`CCM_PSW_AC] = sum5[4];
      psw_n[`CCM_PSW_OV] = (acc_q[7] == addx[7]) && (sum9[7] != acc_q[7]);
    end
    // Direct writes above the RAM half land in special registers
    if (dst_we && dst_dir[`CCM_DIR_SFR]) begin
      case (dst_dir)
        `CCM_SFR_P0: p0_n = dst_val;
        `CCM_SFR_SP: sp_n = dst_val;
        `CCM_SFR_DPL: dptr_n[7:0] = dst_val;
        `CCM_SFR_DPH: dptr_n[15:8] = dst_val;
        `CCM_SFR_PROGRAM_STORE_CONTROL: program_store_control_n = dst_val[`CCM_PROGRAM_STORE_CONTROL_WE];
        `CCM_SFR_PSW: psw_n = dst_val;
        `CCM_SFR_ACC: acc_n = dst_val;
        default: ;
      endcase
    end
    done_n = (last && ext_n == `CCM_EXT_NONE && !take)
           || (st_q == ST_BUBBLE)
           || (st_q == ST_EXTRA && ext_q == `CCM_EXT_ONE);
  end

  // RAM write port: indirect/register/stack, or direct below 0x80
  assign mif.w_en = ind_we || (dst_we && !dst_dir[`CCM_DIR_SFR]);
  assign mif.w_addr = ind_we ? ind_addr : dst_dir;
  assign mif.w_data = ind_we ? ind_val : dst_val;

  // Sequencer: one byte per clock, data cycles, taken-branch bubble
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= ST_FETCH;
      pc_q <= `CCM_RESET_PC;
      cnt_q <= 2'd0;
      ext_q <= `CCM_EXT_NONE;
      op_q <= 8'h00;
      b1_q <= 8'h00;
      tgt_q <= `CCM_RESET_PC;
      hold_q <= 8'h00;
      done_q <= 1'b0;
    end else if (clk_en) begin
      pc_q <= pc_n;
      hold_q <= hold_n;
      done_q <= done_n;
      if (save_tgt) begin
        tgt_q <= tgt_n;
      end
      case (st_q)
        ST_FETCH: begin
          op_q <= opc;
          if (cnt_q == 2'd1) begin
            b1_q <= cur;
          end
          if (!last) begin
            cnt_q <= cnt_q + 2'd1;
          end else begin
            cnt_q <= 2'd0;
            if (ext_n != `CCM_EXT_NONE) begin
              st_q <= ST_EXTRA;
              ext_q <= ext_n;
            end else if (take) begin
              st_q <= ST_BUBBLE;
            end
          end
        end
        ST_EXTRA: begin
          ext_q <= ext_q - 2'd1;
          if (ext_q == `CCM_EXT_ONE) begin
            st_q <= ST_FETCH;
          end
        end
        default: st_q <= ST_FETCH;
      endcase
    end
  end

  // Architectural registers; parity follows the accumulator
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_q <= 8'h00;
      psw_q <= 8'h00;
      sp_q <= `CCM_SP_RST;
      p0_q <= `CCM_P0_RST;
      dptr_q <= 16'h0000;
      program_store_control_we_q <= 1'b0;
    end else if (clk_en) begin
      acc_q <= acc_n;
      psw_q <= {psw_n[7:1], ^acc_n};
      sp_q <= sp_n;
      p0_q <= p0_n;
      dptr_q <= dptr_n;
      program_store_control_we_q <= program_store_control_n;
    end
  end

  // Outputs straight from registers
  assign pc = pc_q;
  assign acc = acc_q;
  assign program_status_word = psw_q;
  assign p0 = p0_q;
  assign instr_done = done_q;
endmodule
`default_nettype wire

/* File: verification/ccm_core_asserts.sv */
// Checker for the compact CPU core: reset, timing and commit relations.
// Assumes it is bound onto ccm_core and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module ccm_core_asserts (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic ld_en,
  input wire ccm_pkg::ccm_addr_t ld_addr,
  input wire ccm_pkg::ccm_byte_t ld_data,
  input wire ccm_pkg::ccm_addr_t pc,
  input wire ccm_pkg::ccm_byte_t acc,
  input wire ccm_pkg::ccm_byte_t program_status_word,
  input wire ccm_pkg::ccm_byte_t p0,
  input wire logic instr_done
);
  import ccm_pkg::*;
  logic [3:0] gap_q;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // Enabled cycles since the last completion pulse
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) gap_q <= 4'h0;
    else if (instr_done) gap_q <= 4'h0;
    else if (clk_en && gap_q != 4'hF) gap_q <= gap_q + 4'h1;
  end
  reset_vals_a: assert property (
    $rose(arst_n) |-> pc == 16'h0000 && acc == 8'h00 && p0 == 8'hFF
    && program_status_word == 8'h00 && !instr_done)
    else $error("core state wrong just after reset");
  first_fetch_a: assert property (
    $rose(arst_n) && clk_en |=> pc == 16'h0001)
    else $error("first fetch not from address zero");
  // Longest instruction is four cycles, well inside eight
  done_bound_a: assert property (gap_q <= 4'h3)
    else $error("instruction ran too long");
  freeze_a: assert property (
    !clk_en |=> $stable(pc) && $stable(acc) && $stable(program_status_word) && $stable(p0))
    else $error("state moved while clock enable low");
  parity_a: assert property ($stable(acc) |-> program_status_word[0] == ^acc)
    else $error("parity flag does not match accumulator");
  acc_commit_a: assert property ($changed(acc) |-> instr_done)
    else $error("accumulator changed outside completion");
  p0_commit_a: assert property ($changed(p0) |-> instr_done)
    else $error("port register changed outside completion");
  psw_commit_a: assert property (
    !$stable(program_status_word[7:1]) |-> instr_done)
    else $error("status word changed outside completion");
endmodule
bind ccm_core ccm_core_asserts u_asserts (.ref_clk(ref_clk),
  .arst_n(arst_n), .clk_en(clk_en), .ld_en(ld_en), .ld_addr(ld_addr),
  .ld_data(ld_data), .pc(pc), .acc(acc), .program_status_word(program_status_word), .p0(p0),
  .instr_done(instr_done));
`default_nettype wire

/* File: verification/ccm_loader.sv */
// Loader model: writes program bytes into the core's flash port.
// Assumes the bench holds the core in reset while it loads.
`timescale 1ns/1ps
`default_nettype none
`include "ccm_params.svh"
module ccm_loader (
  input wire logic ref_clk,
  output var logic ld_en,
  output var ccm_pkg::ccm_addr_t ld_addr,
  output var ccm_pkg::ccm_byte_t ld_data
);
  import ccm_pkg::*;
  // Quiet port at time zero
  initial begin
    ld_en = 1'b0;
    ld_addr = 16'h0000;
    ld_data = 8'h00;
  end
  // One byte per strobe; factory pages never take user code
  task automatic put(input ccm_addr_t a, input ccm_byte_t d);
    if (a >= `CCM_RSV_LO && a <= `CCM_RSV_HI) return;
    @(posedge ref_clk);
    ld_en <= 1'b1;
    ld_addr <= a;
    ld_data <= d;
  endtask
  // Strobe dropped; lines no longer show the last byte
  task automatic idle();
    @(posedge ref_clk);
    ld_en <= 1'b0;
    ld_addr <= ~ld_addr;
    ld_data <= ~ld_data;
  endtask
endmodule
`default_nettype wire

/* File: verification/compact_8bit_cpu_core_memmap_tb.sv */
// Bench: loads a program, runs it, checks cycle counts and core state.
// Assumes the core, its memories and the loader model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin \
  samples_checked++; \
  if ((got) !== (exp)) begin \
    n_mismatch++; \
    $display("Error at %0t: got %h expected %h", $time, got, exp); \
  end \
end
module compact_8bit_cpu_core_memmap_tb;
  import ccm_pkg::*;
  logic ref_clk, arst_n, clk_en, ld_en, instr_done;
  ccm_addr_t ld_addr, pc;
  ccm_byte_t ld_data, acc, program_status_word, p0;
  int n_mismatch, samples_checked;
  localparam ccm_byte_t PROG_A [25] = '{8'h74, 8'h5A, 8'hA5, 8'h04,
    8'hF5, 8'h80, 8'h75, 8'hD0, 8'h08, 8'hF8, 8'h75, 8'hD0, 8'h00,
    8'hE5, 8'h08, 8'h60, 8'h10, 8'hE4, 8'h60, 8'h02, 8'h04, 8'h04,
    8'h02, 8'h00, 8'h30};
  localparam ccm_byte_t PROG_B [11] = '{8'h75, 8'h00, 8'h80, 8'h74,
    8'h3C, 8'hF6, 8'hE5, 8'h80, 8'hE6, 8'h21, 8'h00};
  // Extended RAM and program store moves, then a self loop
  localparam ccm_byte_t PROG_C [19] = '{8'h90, 8'h01, 8'h40, 8'hF0,
    8'hE4, 8'hE0, 8'h75, 8'h8F, 8'h01, 8'h04, 8'hF0, 8'h75, 8'h8F,
    8'h00, 8'hE4, 8'h93, 8'hE0, 8'h80, 8'hFE};
  ccm_core uut (.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en),
    .ld_en(ld_en), .ld_addr(ld_addr), .ld_data(ld_data), .pc(pc),
    .acc(acc), .program_status_word(program_status_word), .p0(p0), .instr_done(instr_done));
  ccm_loader ld (.ref_clk(ref_clk), .ld_en(ld_en), .ld_addr(ld_addr),
    .ld_data(ld_data));
  // Wait for one completion, count its cycles, check pc and acc
  task automatic step(input int cyc, input ccm_addr_t epc,
      input ccm_byte_t eacc);
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (instr_done !== 1'b1 && n < 20);
    if (cyc > 0) `CHK(n, cyc)
    `CHK(pc, epc)
    `CHK(acc, eacc)
  endtask
  task automatic load_all();
    for (int i = 0; i < 25; i++) ld.put(16'(i), PROG_A[i]);
    for (int i = 0; i < 11; i++) ld.put(16'(i + 48), PROG_B[i]);
    for (int i = 0; i < 19; i++) ld.put(16'(i + 256), PROG_C[i]);
    ld.idle();
  endtask
  task automatic t_moves();
    step(2, 16'h0002, 8'h5A);
    step(1, 16'h0003, 8'h5A);
    step(1, 16'h0004, 8'h5B);
    step(2, 16'h0006, 8'h5B);
    `CHK(p0, 8'h5B)
  endtask
  task automatic t_banks();
    step(3, 16'h0009, 8'h5B);
    `CHK(program_status_word, 8'h09)
    step(1, 16'h000A, 8'h5B);
    step(3, 16'h000D, 8'h5B);
    `CHK(program_status_word, 8'h01)
    step(2, 16'h000F, 8'h5B);
  endtask
  task automatic t_branch();
    step(2, 16'h0011, 8'h5B);
    step(1, 16'h0012, 8'h00);
    `CHK(program_status_word, 8'h00)
    step(3, 16'h0016, 8'h00);
    step(4, 16'h0030, 8'h00);
  endtask
  task automatic t_indirect();
    step(3, 16'h0033, 8'h00);
    step(2, 16'h0035, 8'h3C);
    step(1, 16'h0036, 8'h3C);
    `CHK(p0, 8'h5B)
    step(2, 16'h0038, 8'h5B);
    step(1, 16'h0039, 8'h3C);
  endtask
  // Extended RAM, program store write enable, table read, self loop
  task automatic t_jumps();
    step(3, 16'h0100, 8'h3C);
    step(3, 16'h0103, 8'h3C);
    step(3, 16'h0104, 8'h3C);
    step(1, 16'h0105, 8'h00);
    step(3, 16'h0106, 8'h3C);
    step(3, 16'h0109, 8'h3C);
    step(1, 16'h010A, 8'h3D);
    step(3, 16'h010B, 8'h3D);
    step(3, 16'h010E, 8'h3D);
    step(1, 16'h010F, 8'h00);
    step(3, 16'h0110, 8'h3D);
    step(3, 16'h0111, 8'h3C);
    step(3, 16'h0111, 8'h3C);
  endtask
  // Clock enable low holds everything, even mid-instruction
  task automatic t_freeze();
    ccm_addr_t s;
    @(posedge ref_clk);
    clk_en <= 1'b0;
    @(posedge ref_clk);
    #1;
    s = pc;
    repeat (4) @(posedge ref_clk);
    #1;
    `CHK(pc, s)
    `CHK(acc, 8'h3C)
    @(posedge ref_clk);
    clk_en <= 1'b1;
    step(0, 16'h0111, 8'h3C);
  endtask
  // Second reset in mid-run restarts at address zero
  task automatic t_reset();
    @(posedge ref_clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK(pc, 16'h0000)
    `CHK(acc, 8'h00)
    `CHK(p0, 8'hFF)
    `CHK(program_status_word, 8'h00)
    @(posedge ref_clk);
    arst_n <= 1'b1;
    step(2, 16'h0002, 8'h5A);
    step(1, 16'h0003, 8'h5A);
  endtask
  task automatic end_sim();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Free-running 40 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // Main sequence: load under reset, then the scenarios
  initial begin
    arst_n = 1'b0;
    clk_en = 1'b1;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (2) @(posedge ref_clk);
    load_all();
    @(posedge ref_clk);
    arst_n <= 1'b1;
    t_moves();
    t_banks();
    t_branch();
    t_indirect();
    t_jumps();
    t_freeze();
    t_reset();
    end_sim();
  end
  // Hang guard, far beyond the roughly 150 cycles needed
  initial begin
    repeat (3000) @(posedge ref_clk);
    n_mismatch++;
    end_sim();
  end
endmodule
`default_nettype wire
